// *** rtl/svcs_pkg.sv ***
// constants, codes and register map for the servo command selector
package svcs_pkg;
	localparam int NUM_IN  = 8;
	localparam int NUM_SPD = 3;
	localparam int NUM_POS = 8;
	localparam int NUM_EV  = 4;
	localparam int AW      = 8;
	localparam int DW      = 32;

	// register word addresses
	localparam logic [AW-1:0] A_MODE    = 8'h00;
	localparam logic [AW-1:0] A_ABSREL  = 8'h01;
	localparam logic [AW-1:0] A_RESTART = 8'h02;
	localparam logic [AW-1:0] A_IRQ_ST  = 8'h03;
	localparam logic [AW-1:0] A_IRQ_CLR = 8'h04;
	localparam logic [AW-1:0] A_IRQ_EN  = 8'h05;
	localparam logic [AW-1:0] A_STATUS  = 8'h06;
	localparam logic [AW-1:0] A_ASG     = 8'h08;
	localparam logic [AW-1:0] A_SPD     = 8'h10;
	localparam logic [AW-1:0] A_ROT     = 8'h20;
	localparam logic [AW-1:0] A_PUL     = 8'h28;
	localparam logic [AW-1:0] A_MVS     = 8'h30;

	// operating mode codes
	localparam logic [7:0] MODE_POS_CODE = 8'h01;
	localparam logic [7:0] MODE_SPD_CODE = 8'h02;
	localparam logic [7:0] MODE_RST      = 8'h02;
	localparam logic       ABSREL_RST    = 1'b0;

	// input function codes
	localparam logic [7:0] FN_NONE      = 8'h00;
	localparam logic [7:0] FN_ESTOP     = 8'h15;
	localparam logic [7:0] FN_REV       = 8'h16;
	localparam logic [7:0] FN_FWD       = 8'h17;
	localparam logic [7:0] FN_SERVO_EN  = 8'h65;
	localparam logic [7:0] FN_FLT_RESET = 8'h66;
	localparam logic [7:0] FN_POS_TRIG  = 8'h6C;
	localparam logic [7:0] FN_TRQ       = 8'h6D;
	localparam logic [7:0] FN_PSEL0     = 8'h6F;
	localparam logic [7:0] FN_PSEL1     = 8'h70;
	localparam logic [7:0] FN_PSEL2     = 8'h71;
	localparam logic [7:0] FN_SSEL0     = 8'h72;
	localparam logic [7:0] FN_SSEL1     = 8'h73;

	localparam logic [7:0] ASG_RST [NUM_IN] = '{FN_SERVO_EN, FN_TRQ, FN_SSEL0, FN_SSEL1,
		FN_FLT_RESET, FN_REV, FN_FWD, FN_ESTOP};

	// value limits
	localparam logic [15:0] SPD_LIM = 16'h1388;
	localparam logic [15:0] ROT_LIM = 16'h7530;

	// interrupt event bits
	localparam int EV_REV = 0;
	localparam int EV_FWD = 1;
	localparam int EV_EST = 2;
	localparam int EV_TRG = 3;

	// status register fields
	localparam int ST_FLT   = 0;
	localparam int ST_MODE  = 4;
	localparam int ST_ABS   = 6;
	localparam int ST_SEL   = 8;
	localparam int ST_SERVO = 12;
	localparam int ST_ANA   = 13;

	typedef enum logic [1:0] {SVCS_IDLE, SVCS_POS, SVCS_SPD} svcs_mode_t;
endpackage : svcs_pkg

// *** rtl/svcs_selector.sv ***
// servo command selector: input function mapping, speed and position choice
//
// The plain strobed port and the register addresses were decided locally.
module svcs_selector
	import svcs_pkg::*;
(
	// clock and reset
	input  wire logic          CLOCK,
	input  wire logic          RST,
	// register port
	input  wire logic [AW-1:0] REG_ADDR,
	input  wire logic [DW-1:0] REG_WDATA,
	input  wire logic          REG_WR,
	input  wire logic          REG_RD,
	output logic      [DW-1:0] REG_RDATA,
	output logic               IRQ,
	// digital input pins, bit 0 is input one
	input  wire logic [NUM_IN-1:0] DIN,
	// drive control
	output logic               SERVO_ON,
	output logic               TORQUE_LIMIT,
	output logic               SPEED_MODE,
	output logic               POSITION_MODE,
	output logic               FAULT_REV,
	output logic               FAULT_FWD,
	output logic               FAULT_ESTOP,
	// speed command
	output logic               ANALOG_SELECT,
	output logic [15:0]        SPEED_CMD,
	output logic               SPEED_CCW,
	// position command
	output logic               POS_STROBE,
	output logic [15:0]        POS_ROTATION,
	output logic [23:0]        POS_PULSES,
	output logic [15:0]        POS_SPEED,
	output logic               POS_ABSOLUTE
);

	function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] lim);
		logic signed [31:0] s;
		logic signed [31:0] l;
		s = signed'(v);
		l = signed'({16'h0000, lim});
		if (s > l)
			sat = lim;
		else if (s < -l)
			sat = 16'h0000 - lim;
		else
			sat = v[15:0];
	endfunction : sat

	// input synchroniser
	logic [NUM_IN-1:0] din_s1;
	logic [NUM_IN-1:0] din;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			din_s1 <= '0;
			din    <= '0;
		end else begin
			din_s1 <= DIN;
			din    <= din_s1;
		end
	end

	// configuration registers
	logic [7:0]  mode_p;
	logic        absrel_p;
	logic [7:0]  asg   [NUM_IN];
	logic [15:0] spd   [NUM_SPD];
	logic [15:0] rot   [NUM_POS];
	logic [23:0] pul   [NUM_POS];
	logic [15:0] mvs   [NUM_POS];
	logic [NUM_EV-1:0] irq_en;
	logic [7:0]  next_mode_p;
	logic        next_absrel_p;
	logic [7:0]  next_asg [NUM_IN];
	logic [15:0] next_spd [NUM_SPD];
	logic [15:0] next_rot [NUM_POS];
	logic [23:0] next_pul [NUM_POS];
	logic [15:0] next_mvs [NUM_POS];
	logic [NUM_EV-1:0] next_irq_en;
	logic        restart;

	assign restart = REG_WR && (REG_ADDR == A_RESTART);

	always_comb begin
		next_mode_p   = mode_p;
		next_absrel_p = absrel_p;
		next_asg      = asg;
		next_spd      = spd;
		next_rot      = rot;
		next_pul      = pul;
		next_mvs      = mvs;
		next_irq_en   = irq_en;
		if (REG_WR) begin
			case (REG_ADDR)
				A_MODE:   next_mode_p = REG_WDATA[7:0];
				A_ABSREL: next_absrel_p = REG_WDATA[0];
				A_IRQ_EN: next_irq_en = REG_WDATA[NUM_EV-1:0];
				default: ;
			endcase
			if (REG_ADDR[7:3] == A_ASG[7:3])
				next_asg[REG_ADDR[2:0]] = REG_WDATA[7:0];
			if (REG_ADDR[7:2] == A_SPD[7:2] && REG_ADDR[1:0] < 2'(NUM_SPD))
				next_spd[REG_ADDR[1:0]] = sat(REG_WDATA, SPD_LIM);
			if (REG_ADDR[7:3] == A_ROT[7:3])
				next_rot[REG_ADDR[2:0]] = sat(REG_WDATA, ROT_LIM);
			if (REG_ADDR[7:3] == A_PUL[7:3])
				next_pul[REG_ADDR[2:0]] = REG_WDATA[23:0];
			if (REG_ADDR[7:3] == A_MVS[7:3])
				next_mvs[REG_ADDR[2:0]] = sat(REG_WDATA, SPD_LIM);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mode_p   <= MODE_RST;
			absrel_p <= ABSREL_RST;
			asg      <= ASG_RST;
			spd      <= '{default: '0};
			rot      <= '{default: '0};
			pul      <= '{default: '0};
			mvs      <= '{default: '0};
			irq_en   <= '0;
		end else begin
			mode_p   <= next_mode_p;
			absrel_p <= next_absrel_p;
			asg      <= next_asg;
			spd      <= next_spd;
			rot      <= next_rot;
			pul      <= next_pul;
			mvs      <= next_mvs;
			irq_en   <= next_irq_en;
		end
	end

	// active settings, loaded only by reset or the restart register
	svcs_mode_t act_mode;
	svcs_mode_t next_act_mode;
	logic       act_rel;
	logic       next_act_rel;

	always_comb begin
		next_act_mode = act_mode;
		next_act_rel  = act_rel;
		if (restart) begin
			next_act_rel = absrel_p;
			case (mode_p)
				MODE_SPD_CODE: next_act_mode = SVCS_SPD;
				MODE_POS_CODE: next_act_mode = SVCS_POS;
				default:       next_act_mode = SVCS_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			act_mode <= SVCS_SPD;
			act_rel  <= ABSREL_RST;
		end else begin
			act_mode <= next_act_mode;
			act_rel  <= next_act_rel;
		end
	end

	// function decode: a level of 1 is ON, 0 is OFF
	logic       servo_enable_input;
	logic       fault_reset_input;
	logic       f_trg;
	logic       f_trq;
	logic [2:0] f_pos;
	logic [1:0] f_spd;
	logic [2:0] bad;

	always_comb begin
		servo_enable_input = 1'b0;
		fault_reset_input  = 1'b0;
		f_trg              = 1'b0;
		f_trq              = 1'b0;
		f_pos              = '0;
		f_spd              = '0;
		bad                = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			case (asg[i])
				FN_SERVO_EN:  servo_enable_input = servo_enable_input | din[i];
				FN_FLT_RESET: fault_reset_input = fault_reset_input | din[i];
				FN_POS_TRIG:  f_trg = f_trg | din[i];
				FN_TRQ:       f_trq = f_trq | din[i];
				FN_PSEL0:     f_pos[0] = f_pos[0] | din[i];
				FN_PSEL1:     f_pos[1] = f_pos[1] | din[i];
				FN_PSEL2:     f_pos[2] = f_pos[2] | din[i];
				FN_SSEL0:     f_spd[0] = f_spd[0] | din[i];
				FN_SSEL1:     f_spd[1] = f_spd[1] | din[i];
				// limit and stop inputs are fail-safe: an open contact faults
				FN_REV:   bad[EV_REV] = bad[EV_REV] | ~din[i];
				FN_FWD:   bad[EV_FWD] = bad[EV_FWD] | ~din[i];
				FN_ESTOP: bad[EV_EST] = bad[EV_EST] | ~din[i];
				default: ;
			endcase
		end
	end

	// faults and edge history
	logic [2:0] flt;
	logic [2:0] next_flt;
	logic       fault_reset_prev;
	logic       trg_prev;
	logic       flt_clr;

	assign flt_clr = restart | (fault_reset_input & ~fault_reset_prev);

	always_comb begin
		// a fault still present sets again in the clearing cycle
		next_flt = (flt & ~{3{flt_clr}}) | bad;
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			flt              <= '0;
			fault_reset_prev <= 1'b0;
			trg_prev         <= 1'b0;
		end else begin
			flt              <= next_flt;
			fault_reset_prev <= fault_reset_input;
			trg_prev         <= f_trg;
		end
	end

	logic drive_ok;
	assign drive_ok = servo_enable_input & ~(|flt);

	// speed command
	logic        next_servo_on;
	logic        next_trq;
	logic        next_ana;
	logic [15:0] next_cmd;
	logic        next_ccw;

	always_comb begin
		next_servo_on = drive_ok;
		next_trq = drive_ok & f_trq;
		next_ana = 1'b0;
		next_cmd = '0;
		if (drive_ok && act_mode == SVCS_SPD) begin
			case (f_spd)
				2'b00:   next_ana = 1'b1;
				2'b01:   next_cmd = spd[0];
				2'b10:   next_cmd = spd[1];
				default: next_cmd = spd[2];
			endcase
		end
		next_ccw = ~next_cmd[15] & (|next_cmd);
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			SERVO_ON      <= 1'b0;
			TORQUE_LIMIT  <= 1'b0;
			ANALOG_SELECT <= 1'b0;
			SPEED_CMD     <= '0;
			SPEED_CCW     <= 1'b0;
		end else begin
			SERVO_ON      <= next_servo_on;
			TORQUE_LIMIT  <= next_trq;
			ANALOG_SELECT <= next_ana;
			SPEED_CMD     <= next_cmd;
			SPEED_CCW     <= next_ccw;
		end
	end

	// position selection: select bits only matter at the trigger edge
	logic        trg_ev;
	logic [2:0]  sel;
	logic [2:0]  next_sel;
	logic        next_stb;
	logic [15:0] next_prot;
	logic [23:0] next_ppul;
	logic [15:0] next_pspd;

	assign trg_ev = f_trg & ~trg_prev & drive_ok & (act_mode == SVCS_POS);

	always_comb begin
		next_sel  = sel;
		next_stb  = 1'b0;
		next_prot = POS_ROTATION;
		next_ppul = POS_PULSES;
		next_pspd = POS_SPEED;
		if (trg_ev) begin
			next_sel  = f_pos;
			next_stb  = 1'b1;
			next_prot = rot[f_pos];
			next_ppul = pul[f_pos];
			next_pspd = mvs[f_pos];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sel          <= '0;
			POS_STROBE   <= 1'b0;
			POS_ROTATION <= '0;
			POS_PULSES   <= '0;
			POS_SPEED    <= '0;
		end else begin
			sel          <= next_sel;
			POS_STROBE   <= next_stb;
			POS_ROTATION <= next_prot;
			POS_PULSES   <= next_ppul;
			POS_SPEED    <= next_pspd;
		end
	end

	assign POS_ABSOLUTE  = ~act_rel;
	assign SPEED_MODE    = (act_mode == SVCS_SPD);
	assign POSITION_MODE = (act_mode == SVCS_POS);
	assign FAULT_REV     = flt[EV_REV];
	assign FAULT_FWD     = flt[EV_FWD];
	assign FAULT_ESTOP   = flt[EV_EST];

	// interrupts: set beats a simultaneous clear
	logic [NUM_EV-1:0] irq_st;
	logic [NUM_EV-1:0] next_irq_st;
	logic [NUM_EV-1:0] ev;

	always_comb begin
		ev         = '0;
		ev[EV_REV] = next_flt[EV_REV] & ~flt[EV_REV];
		ev[EV_FWD] = next_flt[EV_FWD] & ~flt[EV_FWD];
		ev[EV_EST] = next_flt[EV_EST] & ~flt[EV_EST];
		ev[EV_TRG] = trg_ev;
		next_irq_st = irq_st;
		if (REG_WR && REG_ADDR == A_IRQ_CLR)
			next_irq_st = irq_st & ~REG_WDATA[NUM_EV-1:0];
		next_irq_st = next_irq_st | ev;
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			irq_st <= '0;
		else
			irq_st <= next_irq_st;
	end

	assign IRQ = |(irq_st & irq_en);

	// read path, data valid the cycle after the strobe only
	logic [DW-1:0] rd_val;
	logic [DW-1:0] next_rdata;

	always_comb begin
		rd_val = '0;
		case (REG_ADDR)
			A_MODE:   rd_val[7:0] = mode_p;
			A_ABSREL: rd_val[0] = absrel_p;
			A_IRQ_ST: rd_val[NUM_EV-1:0] = irq_st;
			A_IRQ_EN: rd_val[NUM_EV-1:0] = irq_en;
			A_STATUS: begin
				rd_val[ST_FLT+:3]  = flt;
				rd_val[ST_MODE+:2] = act_mode;
				rd_val[ST_ABS]     = ~act_rel;
				rd_val[ST_SEL+:3]  = sel;
				rd_val[ST_SERVO]   = SERVO_ON;
				rd_val[ST_ANA]     = ANALOG_SELECT;
			end
			default: ;
		endcase
		if (REG_ADDR[7:3] == A_ASG[7:3])
			rd_val[7:0] = asg[REG_ADDR[2:0]];
		if (REG_ADDR[7:2] == A_SPD[7:2] && REG_ADDR[1:0] < 2'(NUM_SPD))
			rd_val = {{16{spd[REG_ADDR[1:0]][15]}}, spd[REG_ADDR[1:0]]};
		if (REG_ADDR[7:3] == A_ROT[7:3])
			rd_val = {{16{rot[REG_ADDR[2:0]][15]}}, rot[REG_ADDR[2:0]]};
		if (REG_ADDR[7:3] == A_PUL[7:3])
			rd_val = {{8{pul[REG_ADDR[2:0]][23]}}, pul[REG_ADDR[2:0]]};
		if (REG_ADDR[7:3] == A_MVS[7:3])
			rd_val = {{16{mvs[REG_ADDR[2:0]][15]}}, mvs[REG_ADDR[2:0]]};
		next_rdata = REG_RD ? rd_val : '0;
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			REG_RDATA <= '0;
		else
			REG_RDATA <= next_rdata;
	end

endmodule : svcs_selector

// *** test/svcs_selector_properties.sv ***
// port checker for the servo command selector, bound to the svcs_selector module
module svcs_selector_chk
	import svcs_pkg::*;
(
	// clock and reset
	input wire logic          CLOCK,
	input wire logic          RST,
	// register read
	input wire logic          REG_RD,
	input wire logic [DW-1:0] REG_RDATA,
	// drive state
	input wire logic          SERVO_ON,
	input wire logic          TORQUE_LIMIT,
	input wire logic          SPEED_MODE,
	input wire logic          POSITION_MODE,
	input wire logic          FAULT_REV,
	input wire logic          FAULT_FWD,
	input wire logic          FAULT_ESTOP,
	// commands
	input wire logic          ANALOG_SELECT,
	input wire logic [15:0]   SPEED_CMD,
	input wire logic          SPEED_CCW,
	input wire logic          POS_STROBE,
	input wire logic [15:0]   POS_ROTATION,
	input wire logic [23:0]   POS_PULSES,
	input wire logic [15:0]   POS_SPEED
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == '0)
		else $error("read data not zero outside read slot");
	chk_strobe_single: assert property (POS_STROBE |=> !POS_STROBE)
		else $error("position strobe longer than one cycle");
	chk_pos_hold: assert property (!POS_STROBE |->
		$stable(POS_ROTATION) && $stable(POS_PULSES) && $stable(POS_SPEED))
		else $error("position command changed without strobe");
	chk_mode_excl: assert property (!(SPEED_MODE && POSITION_MODE))
		else $error("two modes active");
	chk_strobe_mode: assert property (POS_STROBE |-> POSITION_MODE)
		else $error("position strobe outside position mode");
	chk_fault_servo: assert property ((FAULT_REV || FAULT_FWD || FAULT_ESTOP) [*2] |-> !SERVO_ON)
		else $error("drive energised with fault");
	chk_torque_servo: assert property (TORQUE_LIMIT |-> SERVO_ON)
		else $error("torque limit while drive off");
	chk_ccw_sign: assert property (SPEED_CCW == ($signed(SPEED_CMD) > 0))
		else $error("direction does not match speed sign");
	chk_analog_zero: assert property (ANALOG_SELECT |-> SPEED_CMD == '0)
		else $error("internal speed while analog selected");
	chk_speed_span: assert property ($signed(SPEED_CMD) <= 5000 && $signed(SPEED_CMD) >= -5000)
		else $error("speed command out of span");
	chk_rot_span: assert property ($signed(POS_ROTATION) <= 30000 && $signed(POS_ROTATION) >= -30000)
		else $error("rotation count out of span");
endmodule : svcs_selector_chk

bind svcs_selector svcs_selector_chk svcs_selector_chk_inst (
	.CLOCK(CLOCK), .RST(RST), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.SERVO_ON(SERVO_ON), .TORQUE_LIMIT(TORQUE_LIMIT), .SPEED_MODE(SPEED_MODE),
	.POSITION_MODE(POSITION_MODE), .FAULT_REV(FAULT_REV), .FAULT_FWD(FAULT_FWD),
	.FAULT_ESTOP(FAULT_ESTOP), .ANALOG_SELECT(ANALOG_SELECT), .SPEED_CMD(SPEED_CMD),
	.SPEED_CCW(SPEED_CCW), .POS_STROBE(POS_STROBE), .POS_ROTATION(POS_ROTATION),
	.POS_PULSES(POS_PULSES), .POS_SPEED(POS_SPEED));

// *** test/svcs_host_model.sv ***
// host controller model driving the digital command inputs
module svcs_host_model
	import svcs_pkg::*;
(
	// clock
	input wire logic          CLOCK,
	// digital inputs of the drive
	output logic [NUM_IN-1:0] DIN
);
	timeunit 1ns;
	timeprecision 1ps;

	initial DIN = '0;

	task put(input logic [NUM_IN-1:0] v);
		@(posedge CLOCK);
		DIN <= v;
	endtask : put

	// select bits settle first and stay put until well after the trigger is taken
	task fire(input int trg, input int b0, input logic [2:0] sel, input int slow);
		logic [NUM_IN-1:0] v;
		v = DIN;
		v[trg] = 1'b0;
		for (int i = 0; i < 3; i++) begin
			v[b0 + i] = sel[i];
		end
		put(v);
		repeat (3 + slow) @(posedge CLOCK);
		v[trg] = 1'b1;
		put(v);
		repeat (4 + slow) @(posedge CLOCK);
		v[trg] = 1'b0;
		put(v);
		repeat (3) @(posedge CLOCK);
	endtask : fire
endmodule : svcs_host_model

// *** test/svcs_selector_tb_top.sv ***
// self-checking testbench of the servo command selector
module svcs_selector_tb_top
	import svcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              CLOCK = 1'b0;
	logic              RST = 1'b1;
	logic              REG_WR = 1'b0;
	logic              REG_RD = 1'b0;
	logic [AW-1:0]     REG_ADDR = '0;
	logic [DW-1:0]     REG_WDATA = '0;
	logic [DW-1:0]     REG_RDATA;
	logic [NUM_IN-1:0] DIN;
	logic              IRQ, SERVO_ON, TORQUE_LIMIT, SPEED_MODE, POSITION_MODE;
	logic              FAULT_REV, FAULT_FWD, FAULT_ESTOP, ANALOG_SELECT, SPEED_CCW;
	logic              POS_STROBE, POS_ABSOLUTE, tq, seen;
	logic [15:0]       SPEED_CMD, POS_ROTATION, POS_SPEED;
	logic [23:0]       POS_PULSES;
	logic [31:0]       rs = 32'h46D15843;
	logic [31:0]       spd [3];
	logic [31:0]       rot [8];
	logic [31:0]       pul [8];
	logic [31:0]       mvs [8];
	logic [31:0]       rd, e;
	logic [2:0]        sel, r;
	int                n_fail = 0;
	int                compares = 0;

	always #20 CLOCK = ~CLOCK;

	svcs_selector svcs_selector_inst (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.IRQ(IRQ), .DIN(DIN), .SERVO_ON(SERVO_ON), .TORQUE_LIMIT(TORQUE_LIMIT),
		.SPEED_MODE(SPEED_MODE), .POSITION_MODE(POSITION_MODE), .FAULT_REV(FAULT_REV),
		.FAULT_FWD(FAULT_FWD), .FAULT_ESTOP(FAULT_ESTOP), .ANALOG_SELECT(ANALOG_SELECT),
		.SPEED_CMD(SPEED_CMD), .SPEED_CCW(SPEED_CCW), .POS_STROBE(POS_STROBE),
		.POS_ROTATION(POS_ROTATION), .POS_PULSES(POS_PULSES), .POS_SPEED(POS_SPEED),
		.POS_ABSOLUTE(POS_ABSOLUTE));
	svcs_host_model svcs_host_model_inst (.CLOCK(CLOCK), .DIN(DIN));

	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs

	// signed value spread over -lim..lim
	function automatic logic [31:0] rnd_in(input int lim);
		return 32'(int'(xs() % (2 * lim + 1)) - lim);
	endfunction : rnd_in

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge CLOCK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask : wr

	task rdreg(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge CLOCK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		d = REG_RDATA;
	endtask : rdreg

	task settle(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : settle

	task tally_and_finish;
		$display("failures %0d comparisons %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge CLOCK);
		RST <= 1'b0;
		settle(6);
		check(SPEED_MODE, 1);
		check(POS_ABSOLUTE, 1);
		for (int i = 0; i < NUM_IN; i++) begin
			rdreg(AW'(A_ASG + i), rd);
			check(rd, ASG_RST[i]);
		end
		check({FAULT_ESTOP, FAULT_FWD, FAULT_REV}, 3'h7);
		rdreg(A_IRQ_ST, rd);
		check(rd, 32'h7);
		check(IRQ, 0);
		wr(A_IRQ_EN, 32'h1);
		settle(1);
		check(IRQ, 1);
		wr(A_IRQ_CLR, 32'hF);
		settle(1);
		check(IRQ, 0);
		// limits and stop unassigned: their levels must no longer matter
		for (int i = 5; i < 8; i++) wr(AW'(A_ASG + i), FN_NONE);
		wr(A_RESTART, 32'h0);
		svcs_host_model_inst.put({3'(xs()), 5'h00});
		settle(6);
		check({FAULT_ESTOP, FAULT_FWD, FAULT_REV}, 3'h0);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 3; i++) begin
				spd[i] = (p == 0) ? ((i == 2) ? -32'sd3000 : (i == 0 ? 3000 : 100)) : rnd_in(5000);
				wr(AW'(A_SPD + i), spd[i]);
			end
			for (int s = 0; s < 4; s++) begin
				tq = xs() & 1;
				svcs_host_model_inst.put({4'h0, 2'(s), tq, 1'b1});
				settle(5);
				e = '0;
				if (s != 0)
					e = spd[s - 1];
				check(SERVO_ON, 1);
				check(TORQUE_LIMIT, tq);
				check(ANALOG_SELECT, s == 0);
				check(SPEED_CMD, e[15:0]);
				check(SPEED_CCW, $signed(e) > 0);
			end
		end
		svcs_host_model_inst.put(8'h00);
		settle(5);
		check(SERVO_ON, 0);
		check(SPEED_CMD, 0);
		wr(AW'(A_ASG + 7), FN_ESTOP);
		svcs_host_model_inst.put(8'h01);
		settle(5);
		check(FAULT_ESTOP, 1);
		check(SERVO_ON, 0);
		svcs_host_model_inst.put(8'h81);
		svcs_host_model_inst.put(8'h91);
		settle(5);
		check(FAULT_ESTOP, 0);
		check(SERVO_ON, 1);
		wr(AW'(A_ASG + 7), FN_NONE);
		wr(A_MODE, 32'h1);
		wr(A_ABSREL, 32'h1);
		settle(2);
		check(SPEED_MODE, 1);
		check(POS_ABSOLUTE, 1);
		wr(A_RESTART, 32'h0);
		settle(2);
		check({POSITION_MODE, SPEED_MODE}, 2'b10);
		check(POS_ABSOLUTE, 0);
		wr(AW'(A_ASG + 1), FN_POS_TRIG);
		wr(AW'(A_ASG + 2), FN_PSEL0);
		wr(AW'(A_ASG + 3), FN_PSEL1);
		wr(AW'(A_ASG + 4), FN_PSEL2);
		for (int k = 0; k < NUM_POS; k++) begin
			rot[k] = rnd_in(30000);
			pul[k] = rnd_in(8388607);
			mvs[k] = rnd_in(5000);
			wr(AW'(A_ROT + k), rot[k]);
			wr(AW'(A_PUL + k), pul[k]);
			wr(AW'(A_MVS + k), mvs[k]);
		end
		rdreg(A_PUL, rd);
		check(rd, pul[0]);
		rdreg(A_MVS, rd);
		check(rd, mvs[0]);
		svcs_host_model_inst.put(8'h01);
		r = 3'(xs());
		for (int k = 0; k < NUM_POS; k++) begin
			sel = 3'(k) ^ r;
			seen = 1'b0;
			fork
				svcs_host_model_inst.fire(1, 2, sel, k % 2);
				for (int i = 0; i < 30 && !seen; i++) begin
					@(posedge CLOCK);
					#1;
					seen = POS_STROBE;
				end
			join
			if (!seen) begin
				n_fail++;
				tally_and_finish;
			end
			check(POS_ROTATION, rot[sel][15:0]);
			check(POS_PULSES, pul[sel][23:0]);
			check(POS_SPEED, mvs[sel][15:0]);
		end
		rdreg(A_STATUS, rd);
		check(rd, (32'h1 << ST_SERVO) | (32'(sel) << ST_SEL) | (32'h1 << ST_MODE));
		rdreg(A_IRQ_ST, rd);
		check(rd[EV_TRG], 1'b1);
		svcs_host_model_inst.put({3'h0, ~sel, 2'b01});
		settle(8);
		check(POS_ROTATION, rot[sel][15:0]);
		rdreg(8'h40, rd);
		check(rd, 0);
		wr(8'h40, 32'hFFFFFFFF);
		rdreg(8'h40, rd);
		check(rd, 0);
		wr(A_SPD, 32'd6000);
		rdreg(A_SPD, rd);
		check(rd, 32'h1388);
		wr(A_ROT, -32'sd40000);
		rdreg(A_ROT, rd);
		check(rd, 32'hFFFF8AD0);
		wr(A_MODE, 32'h3);
		wr(A_RESTART, 32'h0);
		settle(2);
		check({POSITION_MODE, SPEED_MODE}, 2'b00);
		tally_and_finish;
	end
endmodule : svcs_selector_tb_top
